// [rtl/adc_seq_cfg.svh]
// Constants for the converter sequencer: field positions, reset values
// and timing counts. Assumes inclusion by both ends; the interface does not include it.
// Function
// - Analog selection removes pin's original function
// - Analog selection drops programmed pull-high resistor
// - Analog selection overrides port direction setting
// - Codes 0-3 route inputs, others float
// - Start on complete low-high-low pulse
// - Busy set at initiation, held during
// - Busy cleared at completion
// - Completion raises interrupt request flag
// - Conversion clock is system clock over power-of-two
// - Software keeps conversion clock within range
// - Powered only while enabled; software waits settling
// - Four sample plus eight convert clock periods
// - Conversion runs without stalling the CPU
// - Software disables converter when idle; the CPU end keeps it enabled whenever i_power_req is high
// - Eight-bit read-only result register
// - Reference select 01 picks internal supply
// - First control register bit layout fixed
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// ----------------------------------------------------------------------
// First control register fields
// ----------------------------------------------------------------------
`define CTL0_START_BIT 7
`define CTL0_BUSY_BIT 6
`define CTL0_EN_BIT 5
`define CTL0_CH_MSB 3
`define CTL0_CH_LSB 0
`define CTL0_RESET 8'h00
// ----------------------------------------------------------------------
// Second control register fields
// ----------------------------------------------------------------------
`define CTL1_REF_MSB 4
`define CTL1_REF_LSB 3
`define CTL1_DIV_MSB 2
`define CTL1_DIV_LSB 0
`define CTL1_RESET 8'h00
`define REF_INTERNAL 2'h1
// ----------------------------------------------------------------------
// Timing in conversion clock periods, and the channel count
// ----------------------------------------------------------------------
`define SAMPLE_PERIODS 4'h4
`define CONVERT_PERIODS 4'h8
`define TOTAL_PERIODS 4'hC
`define NUM_CHANNELS 4
`endif

// [rtl/adc_seq_pkg.sv]
// Types used by the device end of the converter sequencer.
// Assumes nothing beyond the constants header.
package adc_seq_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SAMPLE,
    SEQ_CONVERT
  } seq_state_t;
  typedef logic [7:0] byte_t;
endpackage : adc_seq_pkg

// [rtl/adc_sfr_if.sv]
// Special function register link between CPU side and converter.
// Assumes a common clock; the CPU writes whole control bytes.
`timescale 1ns/1ps
interface adc_sfr_if;
  logic ctl0_wr;
  logic [7:0] ctl0_wdata;
  logic ctl1_wr;
  logic [7:0] ctl1_wdata;
  logic [7:0] ctl0_rdata;
  logic [7:0] ctl1_rdata;
  logic [7:0] result_rdata;
  logic conv_done;
  modport dev (
    input ctl0_wr, ctl0_wdata, ctl1_wr, ctl1_wdata,
    output ctl0_rdata, ctl1_rdata, result_rdata, conv_done
  );
  modport cpu (
    output ctl0_wr, ctl0_wdata, ctl1_wr, ctl1_wdata,
    input ctl0_rdata, ctl1_rdata, result_rdata, conv_done
  );
endinterface : adc_sfr_if

// [rtl/adc_seq_dev.sv]
// Converter control end: control registers, start pulse detection,
// clock divider, sample/convert sequence, pin-share override.
// Assumes the analog comparator delivers a byte when asked to sample.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_seq_dev (
  input wire logic i_core_clk, // System clock
  input wire logic i_nrst, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  adc_sfr_if.dev sfr, // Register link
  input wire logic [3:0] i_pin_share, // Pin selected as analog input
  input wire logic [3:0] i_port_out, // Port output data
  input wire logic [3:0] i_port_oe, // Port direction, 1 drives
  input wire logic [3:0] i_pull_en, // Programmed pull-high
  input wire logic [7:0] i_analog_code, // Comparator result byte
  output logic [3:0] o_pin_out, // Pin output data
  output logic [3:0] o_pin_oe, // Pin output enable
  output logic [3:0] o_pull_on, // Pull-high actually connected
  output logic [3:0] o_chan_route, // One-hot analog routing
  output logic o_ref_internal, // Reference from supply
  output logic o_power_on, // Analog power
  output logic o_sample, // Sample switch closed
  output logic o_int_req // Interrupt request pulse
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic start_ff;
  logic nxt_start;
  logic busy_ff;
  logic nxt_busy;
  logic en_ff;
  logic nxt_en;
  logic [3:0] ch_ff;
  logic [3:0] nxt_ch;
  logic [4:0] ctl1_ff;
  logic [4:0] nxt_ctl1;
  logic [7:0] res_ff;
  logic [7:0] nxt_res;
  logic [6:0] div_ff;
  logic [6:0] nxt_div;
  logic [3:0] per_ff;
  logic [3:0] nxt_per;
  logic irq_ff;
  logic nxt_irq;
  adc_seq_pkg::seq_state_t st_ff;
  adc_seq_pkg::seq_state_t nxt_st;
  logic [3:0] pout_ff;
  logic [3:0] poe_ff;
  logic [3:0] pull_ff;
  logic [3:0] route_ff;
  logic ref_ff;
  logic nxt_ref;
  logic samp_ff;
  logic nxt_samp;
  // Divider runs free while idle and is re-phased at each start
  logic tick;
  logic [6:0] div_top;
  // --------------------------------------------------------------------
  // Divider and sequence
  // --------------------------------------------------------------------
  always_comb begin
    // Terminal count of the divider is two to the select, minus one
    div_top = 7'(({7'h0, 1'b1} << ctl1_ff[`CTL1_DIV_MSB:`CTL1_DIV_LSB])
      - 8'h01);
    tick = (div_ff == div_top);
  end
  always_comb begin
    nxt_start = start_ff;
    nxt_en = en_ff;
    nxt_ch = ch_ff;
    nxt_ctl1 = ctl1_ff;
    nxt_busy = busy_ff;
    nxt_res = res_ff;
    nxt_irq = 1'b0;
    nxt_st = st_ff;
    nxt_per = per_ff;
    nxt_div = tick ? 7'h00 : 7'(div_ff + 7'h01);
    // Writes land every enabled cycle; the old start bit marks the edge
    if (sfr.ctl0_wr) begin
      nxt_start = sfr.ctl0_wdata[`CTL0_START_BIT];
      nxt_en = sfr.ctl0_wdata[`CTL0_EN_BIT];
      nxt_ch = sfr.ctl0_wdata[`CTL0_CH_MSB:`CTL0_CH_LSB];
    end
    if (sfr.ctl1_wr)
      nxt_ctl1 = sfr.ctl1_wdata[4:0];
    case (st_ff)
      adc_seq_pkg::SEQ_IDLE: begin
        // Falling start edge after a high completes the pulse
        if (start_ff && !nxt_start && en_ff) begin
          nxt_st = adc_seq_pkg::SEQ_SAMPLE;
          nxt_busy = 1'b1;
          nxt_per = 4'h0;
          nxt_div = 7'h00;
        end
      end
      adc_seq_pkg::SEQ_SAMPLE: begin
        // Runs in hardware; CPU keeps executing meanwhile
        if (tick) begin
          nxt_per = 4'(per_ff + 4'h1);
          if (nxt_per == `SAMPLE_PERIODS)
            nxt_st = adc_seq_pkg::SEQ_CONVERT;
        end
      end
      adc_seq_pkg::SEQ_CONVERT: begin
        if (tick) begin
          nxt_per = 4'(per_ff + 4'h1);
          if (nxt_per == `TOTAL_PERIODS) begin
            nxt_st = adc_seq_pkg::SEQ_IDLE;
            nxt_busy = 1'b0;
            nxt_irq = 1'b1;
            nxt_res = i_analog_code;
          end
        end
      end
      default: nxt_st = adc_seq_pkg::SEQ_IDLE;
    endcase
    // Dropping power before the final tick abandons a conversion; the result is kept
    if (!nxt_en) begin
      nxt_st = adc_seq_pkg::SEQ_IDLE;
      nxt_busy = 1'b0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      start_ff <= 1'b0;
      en_ff <= 1'b0;
      ch_ff <= 4'h0;
      ctl1_ff <= 5'h00;
      busy_ff <= 1'b0;
      res_ff <= 8'h00;
      irq_ff <= 1'b0;
      st_ff <= adc_seq_pkg::SEQ_IDLE;
      per_ff <= 4'h0;
      div_ff <= 7'h00;
    end else if (i_ce) begin
      start_ff <= nxt_start;
      en_ff <= nxt_en;
      ch_ff <= nxt_ch;
      ctl1_ff <= nxt_ctl1;
      busy_ff <= nxt_busy;
      res_ff <= nxt_res;
      irq_ff <= nxt_irq;
      st_ff <= nxt_st;
      per_ff <= nxt_per;
      div_ff <= nxt_div;
    end
  end
  // --------------------------------------------------------------------
  // Pin-share override, one copy per pin
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g++) begin : g_pin
      // Pins handed to the converter lose drive and pull-high on the next enabled clock
      logic nxt_pout;
      logic nxt_poe;
      logic nxt_pull;
      logic nxt_route;
      always_comb begin
        nxt_pout = i_pin_share[g] ? 1'b0 : i_port_out[g];
        nxt_poe = i_pin_share[g] ? 1'b0 : i_port_oe[g];
        nxt_pull = i_pull_en[g] && !i_pin_share[g];
        nxt_route = (ch_ff == 4'(g));
      end
      always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
          pout_ff[g] <= 1'b0;
          poe_ff[g] <= 1'b0;
          pull_ff[g] <= 1'b0;
          route_ff[g] <= 1'b0;
        end else if (i_ce) begin
          pout_ff[g] <= nxt_pout;
          poe_ff[g] <= nxt_poe;
          pull_ff[g] <= nxt_pull;
          route_ff[g] <= nxt_route;
        end
      end
    end
  endgenerate
  // --------------------------------------------------------------------
  // Reference and sample flags
  // --------------------------------------------------------------------
  // Sample flag follows the next state so it lines up with st_ff
  always_comb begin
    nxt_ref = (ctl1_ff[`CTL1_REF_MSB:`CTL1_REF_LSB] == `REF_INTERNAL);
    nxt_samp = (nxt_st == adc_seq_pkg::SEQ_SAMPLE);
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ref_ff <= 1'b0;
      samp_ff <= 1'b0;
    end else if (i_ce) begin
      ref_ff <= nxt_ref;
      samp_ff <= nxt_samp;
    end
  end
  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Read-back comes straight from the control flops, never from inputs
  assign sfr.ctl0_rdata = {start_ff, busy_ff, en_ff, 1'b0, ch_ff};
  assign sfr.ctl1_rdata = {3'h0, ctl1_ff};
  assign sfr.result_rdata = res_ff;
  assign sfr.conv_done = irq_ff;
  assign o_pin_out = pout_ff;
  assign o_pin_oe = poe_ff;
  assign o_pull_on = pull_ff;
  assign o_chan_route = route_ff;
  assign o_ref_internal = ref_ff;
  assign o_power_on = en_ff;
  assign o_sample = samp_ff;
  assign o_int_req = irq_ff;
endmodule : adc_seq_dev

// [rtl/adc_seq_cpu.sv]
// CPU end: writes control bytes, issues the start pulse, holds off
// starting until a settling wait has passed, and captures results.
// Assumes the device end on the same clock.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_seq_cpu (
  input wire logic i_core_clk, // System clock
  input wire logic i_nrst, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  adc_sfr_if.cpu sfr, // Register link
  input wire logic i_power_req, // Want converter powered
  input wire logic [3:0] i_channel, // Channel to convert
  input wire logic [1:0] i_ref_sel, // Reference select
  input wire logic [2:0] i_div_sel, // Divider select
  input wire logic i_go, // Request one conversion
  input wire logic [7:0] i_settle, // Settling wait, clocks
  output logic o_ready, // May request a conversion
  output logic o_busy, // Busy flag as read back
  output logic [7:0] o_result, // Last result
  output logic o_result_valid // Result pulse
);
  logic [2:0] ph_ff, nxt_ph;
  logic [7:0] set_ff, nxt_set;
  logic [7:0] res_ff, nxt_res;
  logic vld_ff, nxt_vld;
  logic rdy_ff, nxt_rdy;
  logic busy_ff;
  logic nxt_busy;
  logic [7:0] w0;
  always_comb begin
    nxt_ph = ph_ff;
    nxt_set = set_ff;
    nxt_res = res_ff;
    nxt_vld = 1'b0;
    nxt_busy = sfr.ctl0_rdata[`CTL0_BUSY_BIT];
    w0 = {1'b0, 1'b0, i_power_req, 1'b0, i_channel};
    // Settling wait restarts whenever power is off
    if (!i_power_req)
      nxt_set = 8'h00;
    else if (set_ff != i_settle)
      nxt_set = 8'(set_ff + 8'h01);
    case (ph_ff)
      3'h0: if (i_go && rdy_ff) nxt_ph = 3'h1;
      3'h1: nxt_ph = 3'h2; // Start high
      3'h2: nxt_ph = 3'h3; // Start low again
      3'h3: if (sfr.conv_done) begin
        nxt_res = sfr.result_rdata;
        nxt_vld = 1'b1;
        nxt_ph = 3'h0;
      end else if (!sfr.ctl0_rdata[`CTL0_EN_BIT]) nxt_ph = 3'h0;
      default: nxt_ph = 3'h0;
    endcase
    nxt_rdy = i_power_req && (set_ff == i_settle) && (nxt_ph == 3'h0);
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ph_ff <= 3'h0;
      set_ff <= 8'h00;
      res_ff <= 8'h00;
      vld_ff <= 1'b0;
      rdy_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (i_ce) begin
      ph_ff <= nxt_ph;
      set_ff <= nxt_set;
      res_ff <= nxt_res;
      vld_ff <= nxt_vld;
      rdy_ff <= nxt_rdy;
      busy_ff <= nxt_busy;
    end
  end
  // First control byte rewritten every enabled cycle, second only in phase 0; start bit high only in phase 1
  assign sfr.ctl0_wr = i_ce;
  assign sfr.ctl0_wdata = (ph_ff == 3'h1) ? (w0 | 8'h80) : w0;
  assign sfr.ctl1_wr = i_ce && (ph_ff == 3'h0);
  assign sfr.ctl1_wdata = {3'h0, i_ref_sel, i_div_sel};
  assign o_ready = rdy_ff;
  assign o_busy = busy_ff;
  assign o_result = res_ff;
  assign o_result_valid = vld_ff;
endmodule : adc_seq_cpu

// [tb/adc_seq_props.sv]
// Checker for the register link between the two converter ends.
// Assumes instantiation beside the link, on the system clock.
`timescale 1ns/1ps
module adc_seq_props (
  input wire logic i_core_clk, // System clock
  input wire logic i_nrst, // Sync reset, active low
  input wire logic ctl0_wr, // First control write strobe
  input wire logic [7:0] ctl0_wdata, // First control write data
  input wire logic [7:0] ctl0_rdata, // First control read back
  input wire logic [7:0] ctl1_rdata, // Second control read back
  input wire logic [7:0] result_rdata, // Result read back
  input wire logic conv_done // Completion pulse
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [11:0] busy_cnt_ff;
  logic [11:0] nxt_busy_cnt;
  logic fall_ff;
  logic nxt_fall;
  logic arm_ff;
  logic nxt_arm;
  always_comb begin
    nxt_busy_cnt = ctl0_rdata[6] ? busy_cnt_ff + 12'h001 : 12'h000;
    nxt_fall = ctl0_wr && !ctl0_wdata[7] && ctl0_rdata[7];
    nxt_arm = nxt_fall && ctl0_wdata[5] && ctl0_rdata[5] && !ctl0_rdata[6];
  end
  // Cleared in reset so no stale count leaks into the next run
  always_ff @(posedge i_core_clk) begin
    busy_cnt_ff <= i_nrst ? nxt_busy_cnt : 12'h000;
    fall_ff <= i_nrst ? nxt_fall : 1'b0;
    arm_ff <= i_nrst ? nxt_arm : 1'b0;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_start_busy;
    arm_ff |-> ctl0_rdata[6];
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy not set after start pulse");
  property p_busy_cause;
    $rose(ctl0_rdata[6]) |-> fall_ff;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy set without start pulse");
  property p_busy_bound;
    ctl0_rdata[6] |-> busy_cnt_ff < 12'h600;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy held too long");
  property p_done_clears;
    conv_done |-> !ctl0_rdata[6] && $past(ctl0_rdata[6]);
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("busy not cleared at completion");
  property p_done_pulse;
    conv_done |=> !conv_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion pulse too long");
  property p_conv_length;
    conv_done |-> busy_cnt_ff == (12'h00C << ctl1_rdata[2:0]);
  endproperty
  a_conv_length: assert property (p_conv_length)
    else $error("conversion length wrong");
  property p_result_load;
    !$stable(result_rdata) |-> conv_done;
  endproperty
  a_result_load: assert property (p_result_load)
    else $error("result changed outside completion");
  property p_busy_needs_en;
    ctl0_rdata[6] |-> ctl0_rdata[5];
  endproperty
  a_busy_needs_en: assert property (p_busy_needs_en)
    else $error("busy while disabled");
  property p_reserved;
    ctl0_rdata[4] == 1'b0 && ctl1_rdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");
endmodule : adc_seq_props

// [tb/adc_conversion_sequencer_tb.sv]
// Bench for both converter ends joined by the register link.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  logic clk = 1'b0, i_nrst = 1'b0, pwr = 1'b0, go = 1'b0;
  logic [3:0] share = 4'h0, pout = 4'h0, poe = 4'h0, pull = 4'h0;
  logic [3:0] ch = 4'h0, pin_out, pin_oe, pull_on, route;
  logic [1:0] rsel = 2'h0;
  logic [2:0] div = 3'h0;
  logic [7:0] code = 8'h00, result, last;
  logic ref_int, power_on, sample, int_req, ready, busy, res_valid;
  logic ce = 1'b1;
  logic [3:0] held;
  int fail_count = 0, compares = 0, irqs = 0, smp = 0, k;
  adc_sfr_if adc_sfr_if_i ();
  adc_seq_dev adc_seq_dev_i (.i_core_clk(clk), .i_nrst(i_nrst),
    .i_ce(ce), .sfr(adc_sfr_if_i.dev), .i_pin_share(share),
    .i_port_out(pout), .i_port_oe(poe), .i_pull_en(pull),
    .i_analog_code(code), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_pull_on(pull_on), .o_chan_route(route), .o_ref_internal(ref_int),
    .o_power_on(power_on), .o_sample(sample), .o_int_req(int_req));
  adc_seq_cpu adc_seq_cpu_i (.i_core_clk(clk), .i_nrst(i_nrst),
    .i_ce(ce), .sfr(adc_sfr_if_i.cpu), .i_power_req(pwr),
    .i_channel(ch), .i_ref_sel(rsel), .i_div_sel(div), .i_go(go),
    .i_settle(8'h10), .o_ready(ready), .o_busy(busy), .o_result(result),
    .o_result_valid(res_valid));
  adc_seq_props adc_seq_props_i (.i_core_clk(clk), .i_nrst(i_nrst),
    .ctl0_wr(adc_sfr_if_i.ctl0_wr), .ctl0_wdata(adc_sfr_if_i.ctl0_wdata),
    .ctl0_rdata(adc_sfr_if_i.ctl0_rdata),
    .ctl1_rdata(adc_sfr_if_i.ctl1_rdata),
    .result_rdata(adc_sfr_if_i.result_rdata),
    .conv_done(adc_sfr_if_i.conv_done));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (int_req === 1'b1) irqs++;
    if (sample === 1'b1) smp++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [3:0] exp_route(input logic [3:0] c);
    return (c < 4'h4) ? 4'h1 << c : 4'h0;
  endfunction : exp_route
  task automatic start(input logic [2:0] d);
    int n;
    n = 0;
    div = d;
    irqs = 0;
    smp = 0;
    // Divider settles before the start pulse reaches the device
    repeat (2) @(negedge clk);
    while (ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk(ready, 1'b1);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask : start
  task automatic convert(input logic [2:0] d, input logic [7:0] c);
    int n;
    n = 0;
    code = c;
    start(d);
    while (res_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk(res_valid, 1'b1);
    chk(result, c);
    chk(16'(irqs), 16'h0001);
    chk(16'(smp), 16'h0004 << d);
  endtask : convert
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    k = $urandom(32'h1571);
    repeat (2) @(negedge clk);
    i_nrst = 1'b1;
    for (k = 0; k < 16; k++) begin
      {share, pout, poe, pull} = (k == 0) ? 16'hFFFF : 16'($urandom);
      repeat (2) @(negedge clk);
      chk(pin_out, pout & ~share);
      chk(pin_oe, poe & ~share);
      chk(pull_on, pull & ~share);
    end
    // Clock enable low must freeze the registered pin output data
    held = pout & ~share;
    ce = 1'b0;
    {share, pout, poe, pull} = ~{share, pout, poe, pull};
    repeat (2) @(negedge clk);
    chk(pin_out, held);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk(pin_out, pout & ~share);
    $display("test pin share done");
    pwr = 1'b1;
    for (k = 0; k < 16; k++) begin
      ch = 4'(k);
      rsel = 2'(k);
      repeat (6) @(negedge clk);
      chk(route, exp_route(ch));
      chk(ref_int, rsel == 2'h1);
      chk(power_on, 1'b1);
    end
    $display("test routing done");
    ch = 4'h0;
    for (k = 0; k < 8; k++) begin
      convert(3'(k), (k == 0) ? 8'hFF : 8'($urandom));
    end
    $display("test conversions done");
    last = result;
    start(3'h7);
    repeat (100) @(negedge clk);
    chk(busy, 1'b1);
    pwr = 1'b0;
    repeat (6) @(negedge clk);
    chk(busy, 1'b0);
    chk(power_on, 1'b0);
    chk(result, last);
    chk(16'(irqs), 16'h0000);
    $display("test abort done");
    report_and_stop();
  end
endmodule : adc_conversion_sequencer_tb
